//--- verilog/wdt_top.sv
// watchdog timer with reset flags behind an apb slave
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - An overflow of the counter while enabled raises a device reset.
// - The watchdog runs only while the key field is 01010 or 10101.
// - Any other key value resets the device after 1 to 2 slow clock cycles.
// - After power-on the key field holds 01010, so the watchdog runs.
// - In run mode a time-out gives a full reset and sets the time-out flag.
// - In sleep a time-out sets the flag and resets only pc and stack pointer.
// - An illegal key write, the clear instruction or halt clears the counter.
// - A single clear instruction clears the counter.
// - The period ranges from 2^8 to 2^18 slow clock cycles.
// - The select field picks 2^8,2^10,2^12,-,-,2^16,2^17,2^18.
// - A reset from an illegal key sets the software-reset flag.
// - The control register returns to 01010011 on all but a warm reset.
// - The low-voltage flag is set by such a reset, cleared by writing zero.
`include "wdt_defs.svh"
module wdt_top
	import wdt_pkg::*;
(
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu events
	input wire logic clear_instr,
	input wire logic halt_instr,
	input wire logic sleep_mode,
	input wire logic low_voltage_event,
	// slow clock from outside
	input wire logic slow_clk,
	// reset requests
	output logic full_reset_req,
	output logic pc_sp_reset_req,
	// interrupt
	output logic irq
);
	logic [7:0] wd_control_q;
	logic [7:0] sys_flags_q;
	logic timeout_flag_q, power_down_flag_q;
	logic [`IRQ_WIDTH-1:0] irq_status_q, irq_mask_q;
	logic warm_q;
	debounce_state_t dbn_q;
	logic [1:0] dbn_cnt_q;
	logic slow_tick, slow_level;
	logic [`CNT_WIDTH-1:0] count;
	logic overflow, key_legal, wd_clear;
	logic wr_en, rd_en, wr_ctrl, wr_cmd, key_fire;
	logic [4:0] key;
	logic [`IRQ_WIDTH-1:0] irq_ev;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign wr_ctrl = wr_en && paddr == `OFS_WD_CONTROL;
	assign wr_cmd = wr_en && paddr == `OFS_CMD;
	assign key = wd_control_q[7:3];
	assign key_legal = key == `WD_KEY_LEGAL_A || key == `WD_KEY_LEGAL_B;
	assign key_fire = dbn_q == dbn_fire;
	// clear sources: halt, instruction (pin or command), illegal key
	assign wd_clear = clear_instr || halt_instr || key_fire
		|| (wr_cmd && pwdata[`BIT_CLR_INSTR]);

	wdt_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(slow_clk),
		.level_out(slow_level),
		.rise_out(slow_tick)
	);

	wdt_counter #(.WIDTH(`CNT_WIDTH)) u_counter (
		.pclk(pclk),
		.presetn(presetn),
		.tick(slow_tick),
		.clear(wd_clear),
		.enable(key_legal),
		.period_sel(wd_control_q[2:0]),
		.count_q(count),
		.overflow(overflow)
	);

	// apb answers in the access cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && paddr != `OFS_WD_CONTROL
				&& paddr != `OFS_SYS_FLAGS && paddr != `OFS_STATUS
				&& paddr != `OFS_IRQ_STATUS && paddr != `OFS_IRQ_MASK
				&& paddr != `OFS_CMD;
		end
	end

	// prdata is registered in the setup cycle, so it is valid when pready goes high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable) begin
			case (paddr)
				`OFS_WD_CONTROL: prdata <= {24'h0, wd_control_q};
				`OFS_SYS_FLAGS: prdata <= {24'h0, sys_flags_q};
				`OFS_STATUS: prdata <= {11'h0, slow_level, timeout_flag_q,
					power_down_flag_q, count[17:0]};
				`OFS_IRQ_STATUS: prdata <= {29'h0, irq_status_q};
				`OFS_IRQ_MASK: prdata <= {29'h0, irq_mask_q};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// control register: keeps its value over a warm time-out reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_control_q <= `WD_CONTROL_RESET;
		end else if (key_fire) begin
			wd_control_q <= `WD_CONTROL_RESET;
		end else if (wr_ctrl && pready) begin
			wd_control_q <= pwdata[7:0];
		end
	end

	// debounce of an illegal key over slow clock ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbn_q <= dbn_idle;
			dbn_cnt_q <= 2'h0;
		end else begin
			case (dbn_q)
				dbn_idle: begin
					dbn_cnt_q <= 2'h0;
					if (!key_legal) begin
						dbn_q <= dbn_wait;
					end
				end
				dbn_wait: begin
					if (key_legal) begin
						dbn_q <= dbn_idle;
					end else if (slow_tick) begin
						if (dbn_cnt_q == 2'(`DEBOUNCE_CYCLES - 1)) begin
							dbn_q <= dbn_fire;
						end
						dbn_cnt_q <= dbn_cnt_q + 2'h1;
					end
				end
				dbn_fire: dbn_q <= dbn_idle;
				default: dbn_q <= dbn_idle;
			endcase
		end
	end

	// system flags; bit 6 reads zero, hardware sets win over software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_flags_q <= `SYS_FLAGS_RESET;
		end else begin
			if (wr_en && pready && paddr == `OFS_SYS_FLAGS) begin
				sys_flags_q <= pwdata[7:0] & `SYS_FLAGS_WMASK;
			end
			if (key_fire) begin
				sys_flags_q[`BIT_WD_SW_RESET] <= 1'b1;
			end
			if (low_voltage_event) begin
				sys_flags_q[`BIT_LOW_VOLT] <= 1'b1;
			end
		end
	end

	// status flags: time-out and power-down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_flag_q <= 1'b0;
			power_down_flag_q <= 1'b0;
		end else if (overflow) begin
			timeout_flag_q <= 1'b1;
			if (sleep_mode) begin
				power_down_flag_q <= 1'b1;
			end
		end else if (halt_instr) begin
			timeout_flag_q <= 1'b0;
			power_down_flag_q <= 1'b1;
		end else if (clear_instr || (wr_cmd && pwdata[`BIT_CLR_INSTR])) begin
			timeout_flag_q <= 1'b0;
			power_down_flag_q <= 1'b0;
		end
	end

	// reset requests, one-cycle pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_reset_req <= 1'b0;
			pc_sp_reset_req <= 1'b0;
			warm_q <= 1'b0;
		end else begin
			full_reset_req <= key_fire || low_voltage_event
				|| (overflow && !sleep_mode);
			pc_sp_reset_req <= overflow && sleep_mode;
			warm_q <= overflow;
		end
	end

	assign irq_ev[`IRQ_TIMEOUT] = warm_q;
	assign irq_ev[`IRQ_KEY_RESET] = key_fire;
	assign irq_ev[`IRQ_LOW_VOLT] = low_voltage_event;

	// sticky interrupt status, write one to clear, set wins
	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_WIDTH; gi++) begin : g_irq
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					irq_status_q[gi] <= 1'b0;
				end else if (irq_ev[gi]) begin
					irq_status_q[gi] <= 1'b1;
				end else if (wr_en && pready && paddr == `OFS_IRQ_STATUS
					&& pwdata[gi]) begin
					irq_status_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_en && pready && paddr == `OFS_IRQ_MASK) begin
				irq_mask_q <= pwdata[`IRQ_WIDTH-1:0];
			end
			irq <= |(irq_status_q & irq_mask_q);
		end
	end
endmodule
`default_nettype wire

//--- verilog/wdt_defs.svh
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define OFS_WD_CONTROL 12'h000
`define OFS_SYS_FLAGS 12'h004
`define OFS_STATUS 12'h008
`define OFS_IRQ_STATUS 12'h00c
`define OFS_IRQ_MASK 12'h010
`define OFS_CMD 12'h014
`define WD_CONTROL_RESET 8'h53
`define WD_KEY_LEGAL_A 5'h0a
`define WD_KEY_LEGAL_B 5'h15
`define SYS_FLAGS_RESET 8'h00
`define SYS_FLAGS_WMASK 8'hbf
`define BIT_WD_SW_RESET 0
`define BIT_SPARE_USER 1
`define BIT_LOW_VOLT 2
`define BIT_CLR_INSTR 0
`define BIT_HALT 1
`define BIT_SLEEP 2
`define DEBOUNCE_CYCLES 2
`define CNT_WIDTH 19
`define IRQ_WIDTH 3
`define IRQ_TIMEOUT 0
`define IRQ_KEY_RESET 1
`define IRQ_LOW_VOLT 2
`endif

//--- verilog/wdt_pkg.sv
// types shared by the watchdog files
package wdt_pkg;
	typedef enum logic [2:0] {
		dbn_idle = 3'b001,
		dbn_wait = 3'b010,
		dbn_fire = 3'b100
	} debounce_state_t;
endpackage

//--- verilog/wdt_sync.sv
// three-stage synchroniser with agreement filter for the slow clock
`timescale 1ns/1ns
`default_nettype none
module wdt_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// async level in, filtered level and rising pulse out
	input wire logic async_in,
	output logic level_out,
	output logic rise_out
);
	logic s1_q, s2_q, s3_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_out <= 1'b0;
			rise_out <= 1'b0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_out <= s3_q;
			end
			rise_out <= (s2_q == s3_q) && s3_q && !level_out;
		end
	end
endmodule
`default_nettype wire

//--- verilog/wdt_counter.sv
// watchdog divider counter with selectable overflow ratio
`timescale 1ns/1ns
`default_nettype none
module wdt_counter #(
	parameter int WIDTH = 19
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic tick,
	input wire logic clear,
	input wire logic enable,
	input wire logic [2:0] period_sel,
	// state
	output logic [WIDTH-1:0] count_q,
	output logic overflow
);
	logic [WIDTH-1:0] limit;
	initial begin
		if (WIDTH < 19) begin
			$error("wdt_counter needs WIDTH of at least 19");
		end
	end
	// reserved codes 011/100 fall back to the nearest lower ratio
	always_comb begin
		case (period_sel)
			3'h0: limit = WIDTH'(1 << 8);
			3'h1: limit = WIDTH'(1 << 10);
			3'h2: limit = WIDTH'(1 << 12);
			3'h3: limit = WIDTH'(1 << 12);
			3'h4: limit = WIDTH'(1 << 12);
			3'h5: limit = WIDTH'(1 << 16);
			3'h6: limit = WIDTH'(1 << 17);
			3'h7: limit = WIDTH'(1 << 18);
			default: limit = WIDTH'(1 << 18);
		endcase
	end
	assign overflow = enable && tick && (count_q == limit - WIDTH'(1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (clear || overflow) begin
			count_q <= '0;
		end else if (tick && enable) begin
			count_q <= count_q + WIDTH'(1);
		end
	end
endmodule
`default_nettype wire

//--- verification/wdt_checker.sv
// port assertions for the watchdog block
`timescale 1ns/1ns
`default_nettype none
module wdt_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// events and requests
	input wire logic clear_instr,
	input wire logic sleep_mode,
	input wire logic low_voltage_event,
	input wire logic full_reset_req,
	input wire logic pc_sp_reset_req
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PREADY: assert property (psel && !penable |=> pready)
		else $error("no ready in access cycle");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held past access");
	AST_SLVERR: assert property (psel && !penable && paddr > 12'h014
		|=> pslverr) else $error("unmapped access not refused");
	AST_SLVERR_READY: assert property (pslverr |-> pready)
		else $error("error outside access cycle");
	AST_LVR: assert property (low_voltage_event |-> ##[1:2] full_reset_req)
		else $error("no full reset after low voltage");
	AST_PCSP_SLEEP: assert property (pc_sp_reset_req |-> $past(sleep_mode))
		else $error("partial reset while awake");
	AST_PCSP_PULSE: assert property ($rose(pc_sp_reset_req) |=> !pc_sp_reset_req)
		else $error("partial reset not a pulse");
	AST_CLEAR: assert property (clear_instr |-> ##2 !pc_sp_reset_req [*8])
		else $error("reset right after clear");
	AST_KEY: assert property (psel && penable && pwrite && paddr == 12'h000
		&& !(pwdata[7:3] inside {5'h0a, 5'h15}) |=> !full_reset_req [*2])
		else $error("illegal key reset without debounce");
endmodule
`default_nettype wire

//--- verification/tb_watchdog_timer_with_reset_flags.sv
// self-checking bench of the watchdog block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_watchdog_timer_with_reset_flags;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic clear_instr, halt_instr, sleep_mode, low_voltage_event, slow_clk;
	logic full_reset_req, pc_sp_reset_req, p, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic [2:0] div;
	int mismatches, checks, n;
	wdt_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .clear_instr, .halt_instr,
		.sleep_mode, .low_voltage_event, .slow_clk, .full_reset_req,
		.pc_sp_reset_req, .irq);
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	// slow clock of eight pclk periods
	always @(posedge pclk) begin
		div <= div + 3'h1;
		slow_clk <= div[2];
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		// one idle edge so the next setup never re-drives psel in this step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	task automatic wait_req(input int lim);
		n = 0;
		while (full_reset_req !== 1'b1 && pc_sp_reset_req !== 1'b1 && n < lim)
			begin @(posedge pclk); n++; end
		p = pc_sp_reset_req;
	endtask
	task automatic pulse(ref logic s);
		s <= 1;
		@(posedge pclk);
		s <= 0;
	endtask
	task t_regs;
		apb(0, 12'h000, 0, v); `CHK(v, 32'h53)
		apb(0, 12'h004, 0, v); `CHK(v, 32'h0)
		wr(12'h004, 32'hff); apb(0, 12'h004, 0, v); `CHK(v, 32'hbf)
		wr(12'h004, 32'h0); apb(0, 12'h004, 0, v); `CHK(v, 32'h0)
		apb(0, 12'h100, 0, v); `CHK({err, v}, 33'h100000000)
		$display("regs done");
	endtask
	task t_period;
		logic [7:0] ctl [3] = '{8'h50, 8'h51, 8'ha8};
		int e [3] = '{256, 1024, 256};
		for (int i = 0; i < 3; i++) begin
			wr(12'h000, {24'h0, ctl[i]}); wr(12'h014, 32'h1);
			wait_req(20000); `CHK(p, 1'b0)
			`CHK(n >= e[i]*8-16 && n <= e[i]*8+32, 1'b1)
		end
		apb(0, 12'h008, 0, v); `CHK(v[19], 1'b1)
		wr(12'h010, 32'h1); repeat (2) @(posedge pclk); `CHK(irq, 1'b1)
		wr(12'h00c, 32'h1); repeat (2) @(posedge pclk); `CHK(irq, 1'b0)
		$display("period done");
	endtask
	task t_sleep;
		sleep_mode <= 1; wr(12'h000, 32'h50); wr(12'h014, 32'h1);
		wait_req(3000); `CHK(p, 1'b1)
		apb(0, 12'h008, 0, v); `CHK(v[19], 1'b1)
		sleep_mode <= 0;
		$display("sleep done");
	endtask
	task t_clear;
		for (int i = 0; i < 6; i++) begin
			wait_req(1200); `CHK(n, 1200)
			if (i % 2) pulse(halt_instr); else pulse(clear_instr);
		end
		apb(0, 12'h008, 0, v); `CHK(v[19:18], 2'b01)
		$display("clear done");
	endtask
	task t_key;
		wr(12'h000, 32'h0); wait_req(200); `CHK(n >= 8 && n < 40, 1'b1)
		apb(0, 12'h000, 0, v); `CHK(v, 32'h53)
		apb(0, 12'h004, 0, v); `CHK(v[0], 1'b1)
		low_voltage_event <= 1; @(posedge pclk); low_voltage_event <= 0;
		wait_req(10); `CHK(n < 10, 1'b1)
		apb(0, 12'h004, 0, v); `CHK(v[2], 1'b1)
		$display("key and lvr done");
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, clear_instr, halt_instr} = 0;
		{sleep_mode, low_voltage_event, slow_clk, paddr, pwdata, div} = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs; t_period; t_sleep; t_clear; t_key;
		end_sim;
	end
	initial begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		end_sim;
	end
endmodule
bind wdt_top wdt_checker chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .clear_instr, .sleep_mode,
	.low_voltage_event, .full_reset_req, .pc_sp_reset_req);
`default_nettype wire
